// ===== verilog/wdt_consts.svh
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
// Notes on behaviour
// - at power-up run a 381 us evaluation of the reset-delay config pin
// - classify reset-delay pin as open, pulled up or capacitor; picks the delay
// - enabling or disabling through the select pins acts at once
// - a new enabled ratio is taken only at a reset event; the code also takes it on enable from the disabled state
// - after disabled-to-enabled, ignore kicks for 150 us
// - capacitor delay: disable during fault releases output; re-enable waits a delay
// - factory delay: disable and re-enable during fault acts as a normal enable
// - four select modes: off (first high, second low), 1:8, 3:4, 1:2
// - while disabled the fault output stays high and kicks are ignored
// - at power-up evaluate the window config pin over 381 us, three classes
// - only a falling edge of the kick input counts as a kick
// - first kick after enable or release has only an upper deadline
// - later kicks in the window keep output high; early or missing kicks fault
// - while faulted, kicks are ignored until the reset delay ends
// - the fault output stays low for exactly the reset delay
// - lower-to-upper ratio: 00 gives 1/8, 11 gives 1/2, 01 gives 3/4
// - factory reset delay: 200 ms when open, 10 ms when pulled up
// - after power-up the watchdog stays off for one reset delay
// ============================================================
// timing, in microseconds, and the clock rate
`define CLK_MHZ 250
`define CYC(us) ((us) * `CLK_MHZ)
`define T_INIT_US 381
`define T_SETUP_US 150
`define T_RST_OPEN_US 200000
`define T_RST_PULL_US 10000
`define T_WDU_OPEN_R8_US 55000
`define T_WDU_OPEN_R34_US 27500
`define T_WDU_OPEN_R12_US 1600000
`define T_WDU_PULL_R8_US 109000
`define T_WDU_PULL_R34_US 195000
`define T_WDU_PULL_R12_US 11000
`define T_WDL_OPEN_R8_US 22500
`define T_WDL_OPEN_R34_US 1850
`define T_WDL_OPEN_R12_US 800000
`define T_WDL_PULL_R8_US 9000
`define T_WDL_PULL_R34_US 9000
`define T_WDL_PULL_R12_US 1850
// ============================================================
// pin classes and select codes {ratio_select_a, ratio_select_b}
`define CLS_OPEN 2'b00
`define CLS_PULL 2'b01
`define CLS_CAP 2'b10
`define SEL_R8 2'b00
`define SEL_R34 2'b01
`define SEL_OFF 2'b10
`define SEL_R12 2'b11
// ============================================================
// register map, byte addresses, and reset values
`define REG_CAP_RST 4'h0
`define REG_CAP_WDU 4'h4
`define REG_STATUS 4'h8
`define REG_FAULTS 4'hc
`define CAP_RST_RV 32'h0002_ab98
`define CAP_WDU_RV 32'h0001_0000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ===== verilog/wdt_pkg.sv
package wdt_pkg;
  typedef enum logic [2:0] {
    ST_EVAL = 3'b000,
    ST_STARTUP = 3'b001,
    ST_DISABLED = 3'b010,
    ST_SETUP = 3'b011,
    ST_FIRST = 3'b100,
    ST_WINDOW = 3'b101,
    ST_FAULT = 3'b110,
    ST_RECOVER = 3'b111
  } wd_state_e;
  typedef logic [1:0] pin_cls_t;
  typedef logic [1:0] ratio_sel_t;
endpackage

// ===== verilog/cfg_pin_eval.sv
`include "wdt_consts.svh"
module cfg_pin_eval import wdt_pkg::*; #(
  parameter logic [31:0] INIT_CYC = `CYC(`T_INIT_US)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pin_cls_t reset_delay_cfg_pin,
  input wire pin_cls_t window_time_cfg_pin,
  output pin_cls_t rst_cls_q,
  output pin_cls_t wnd_cls_q,
  output logic eval_done
);
  logic [31:0] cnt_q;
  logic done_q;
  wire eval_last = !done_q && (cnt_q == INIT_CYC - 32'h1);
  // an unreadable code falls back to the factory default
  wire pin_cls_t rst_d = (reset_delay_cfg_pin == 2'b11) ? `CLS_OPEN : reset_delay_cfg_pin;
  wire pin_cls_t wnd_d = (window_time_cfg_pin == 2'b11) ? `CLS_OPEN : window_time_cfg_pin;
  assign eval_done = done_q || eval_last;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 32'h0;
      done_q <= 1'b0;
      rst_cls_q <= `CLS_OPEN;
      wnd_cls_q <= `CLS_OPEN;
    end else if (!done_q) begin
      cnt_q <= cnt_q + 32'h1;
      if (eval_last) begin
        done_q <= 1'b1;
        rst_cls_q <= rst_d;
        wnd_cls_q <= wnd_d;
      end
    end
  end
endmodule

// ===== verilog/axil_regs.sv
`include "wdt_consts.svh"
module axil_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [31:0] status_word,
  input wire logic [31:0] fault_count,
  output logic [31:0] cap_rst_q,
  output logic [31:0] cap_wdu_q
);
  logic aw_full_q, w_full_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] wmask;
  assign awready = !aw_full_q && !bvalid;
  assign wready = !w_full_q && !bvalid;
  assign arready = !rvalid;
  wire do_write = aw_full_q && w_full_q && !bvalid;
  wire [3:0] wa = {awaddr_q[3:2], 2'b00};
  wire [3:0] ra = {araddr[3:2], 2'b00};
  wire wr_rst = do_write && (wa == `REG_CAP_RST);
  wire wr_wdu = do_write && (wa == `REG_CAP_WDU);
  wire wr_hit = (wa == `REG_CAP_RST) || (wa == `REG_CAP_WDU) || (wa == `REG_STATUS) ||
                (wa == `REG_FAULTS);
  wire rd_hit = (ra == `REG_CAP_RST) || (ra == `REG_CAP_WDU) || (ra == `REG_STATUS) ||
                (ra == `REG_FAULTS);
  wire [31:0] rd_mux = (ra == `REG_CAP_RST) ? cap_rst_q :
                       (ra == `REG_CAP_WDU) ? cap_wdu_q :
                       (ra == `REG_STATUS) ? status_word :
                       (ra == `REG_FAULTS) ? fault_count : 32'h0;
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign wmask[g*8 +: 8] = {8{wstrb_q[g]}};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
      cap_rst_q <= `CAP_RST_RV;
      cap_wdu_q <= `CAP_WDU_RV;
    end else begin
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (wr_rst) cap_rst_q <= (cap_rst_q & ~wmask) | (wdata_q & wmask);
      if (wr_wdu) cap_wdu_q <= (cap_wdu_q & ~wmask) | (wdata_q & wmask);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== verilog/window_watchdog_timer.sv
`include "wdt_consts.svh"
module window_watchdog_timer import wdt_pkg::*; #(
  parameter logic [31:0] INIT_CYC = `CYC(`T_INIT_US),
  parameter logic [31:0] SETUP_CYC = `CYC(`T_SETUP_US),
  parameter logic [31:0] RST_OPEN_CYC = `CYC(`T_RST_OPEN_US),
  parameter logic [31:0] RST_PULL_CYC = `CYC(`T_RST_PULL_US),
  parameter logic [31:0] WDU_OPEN_R8 = `CYC(`T_WDU_OPEN_R8_US),
  parameter logic [31:0] WDU_OPEN_R34 = `CYC(`T_WDU_OPEN_R34_US),
  parameter logic [31:0] WDU_OPEN_R12 = `CYC(`T_WDU_OPEN_R12_US),
  parameter logic [31:0] WDU_PULL_R8 = `CYC(`T_WDU_PULL_R8_US),
  parameter logic [31:0] WDU_PULL_R34 = `CYC(`T_WDU_PULL_R34_US),
  parameter logic [31:0] WDU_PULL_R12 = `CYC(`T_WDU_PULL_R12_US),
  parameter logic [31:0] WDL_OPEN_R8 = `CYC(`T_WDL_OPEN_R8_US),
  parameter logic [31:0] WDL_OPEN_R34 = `CYC(`T_WDL_OPEN_R34_US),
  parameter logic [31:0] WDL_OPEN_R12 = `CYC(`T_WDL_OPEN_R12_US),
  parameter logic [31:0] WDL_PULL_R8 = `CYC(`T_WDL_PULL_R8_US),
  parameter logic [31:0] WDL_PULL_R34 = `CYC(`T_WDL_PULL_R34_US),
  parameter logic [31:0] WDL_PULL_R12 = `CYC(`T_WDL_PULL_R12_US)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ratio_select_a,
  input wire logic ratio_select_b,
  input wire logic kick_input,
  input wire pin_cls_t reset_delay_cfg_pin,
  input wire pin_cls_t window_time_cfg_pin,
  output logic fault_output_n,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  // ============================================================
  // state and configuration
  wd_state_e state_q, state_d;
  logic [31:0] cnt_q;
  logic kick_q;
  ratio_sel_t ratio_q;
  logic cap_pend_q;
  logic fault_n_q;
  logic [31:0] faults_q;
  logic restart;
  pin_cls_t rst_cls, wnd_cls;
  logic eval_done;
  logic [31:0] cap_rst, cap_wdu;

  cfg_pin_eval #(
    .INIT_CYC(INIT_CYC)
  ) u_eval (
    .aclk(aclk),
    .aresetn(aresetn),
    .reset_delay_cfg_pin(reset_delay_cfg_pin),
    .window_time_cfg_pin(window_time_cfg_pin),
    .rst_cls_q(rst_cls),
    .wnd_cls_q(wnd_cls),
    .eval_done(eval_done)
  );

  wire [31:0] status_word = {19'h0, fault_n_q, wnd_cls, rst_cls, 2'b00, ratio_q, 1'b0,
                             state_q};

  axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .status_word(status_word),
    .fault_count(faults_q),
    .cap_rst_q(cap_rst),
    .cap_wdu_q(cap_wdu)
  );

  // ============================================================
  // decode of pins and limits
  wire ratio_sel_t sel_now = {ratio_select_a, ratio_select_b};
  wire sel_off = (sel_now == `SEL_OFF);
  // kick_q resets high so an idle-high line gives no false edge after reset
  wire kick_fall = kick_q && !kick_input;
  wire rst_is_cap = (rst_cls == `CLS_CAP);
  wire [31:0] rst_lim = rst_is_cap ? cap_rst :
                        (rst_cls == `CLS_PULL) ? RST_PULL_CYC : RST_OPEN_CYC;
  wire r8 = (ratio_q == `SEL_R8);
  wire r34 = (ratio_q == `SEL_R34);
  wire [31:0] wdu_open = r8 ? WDU_OPEN_R8 : r34 ? WDU_OPEN_R34 : WDU_OPEN_R12;
  wire [31:0] wdu_pull = r8 ? WDU_PULL_R8 : r34 ? WDU_PULL_R34 : WDU_PULL_R12;
  wire [31:0] wdl_open = r8 ? WDL_OPEN_R8 : r34 ? WDL_OPEN_R34 : WDL_OPEN_R12;
  wire [31:0] wdl_pull = r8 ? WDL_PULL_R8 : r34 ? WDL_PULL_R34 : WDL_PULL_R12;
  // capacitor window: lower bound derived from the upper by the ratio
  wire [31:0] cap_wdl = r8 ? (cap_wdu >> 3) : r34 ? (cap_wdu - (cap_wdu >> 2)) :
                        (cap_wdu >> 1);
  wire [31:0] wdu_lim = (wnd_cls == `CLS_CAP) ? cap_wdu :
                        (wnd_cls == `CLS_PULL) ? wdu_pull : wdu_open;
  wire [31:0] wdl_lim = (wnd_cls == `CLS_CAP) ? cap_wdl :
                        (wnd_cls == `CLS_PULL) ? wdl_pull : wdl_open;
  wire use_rst = (state_q == ST_STARTUP) || (state_q == ST_FAULT) ||
                 (state_q == ST_RECOVER);
  wire use_wnd = (state_q == ST_FIRST) || (state_q == ST_WINDOW);
  wire [31:0] lim = use_rst ? rst_lim : use_wnd ? wdu_lim :
                    (state_q == ST_SETUP) ? SETUP_CYC : 32'h0;
  wire [32:0] cnt_inc = {1'b0, cnt_q} + 33'h1;
  wire cnt_done = (cnt_inc >= {1'b0, lim});
  wire early = (cnt_q < wdl_lim);
  wire enabled_st = (state_q == ST_SETUP) || use_wnd || (state_q == ST_FAULT) ||
                    (state_q == ST_RECOVER);
  wire fault_entry = (state_d == ST_FAULT) && (state_q != ST_FAULT);
  wire leave_idle = ((state_q == ST_STARTUP) || (state_q == ST_DISABLED)) &&
                    (state_d != state_q);
  // a new ratio is taken only at a reset event or on enable
  wire take_ratio = (fault_entry || leave_idle) && !sel_off;
  wire pend_set = (state_q == ST_FAULT) && (state_d == ST_DISABLED) && rst_is_cap;
  wire pend_clr = (state_q == ST_DISABLED) && (state_d != ST_DISABLED);

  // ============================================================
  // sequencer
  always_comb begin
    state_d = state_q;
    restart = 1'b0;
    case (state_q)
      ST_EVAL: begin
        if (eval_done) state_d = ST_STARTUP;
      end
      ST_STARTUP: begin
        if (cnt_done) state_d = sel_off ? ST_DISABLED : ST_SETUP;
      end
      ST_DISABLED: begin
        // capacitor delay still owed after a fault was cut short
        if (!sel_off) state_d = cap_pend_q ? ST_RECOVER : ST_SETUP;
      end
      ST_SETUP: begin
        if (cnt_done) state_d = ST_FIRST;
      end
      ST_FIRST: begin
        if (kick_fall) begin
          state_d = ST_WINDOW;
        end else if (cnt_done) begin
          state_d = ST_FAULT;
        end
      end
      ST_WINDOW: begin
        if (kick_fall) begin
          if (early) begin
            state_d = ST_FAULT;
          end else begin
            restart = 1'b1;
          end
        end else if (cnt_done) begin
          state_d = ST_FAULT;
        end
      end
      ST_FAULT: begin
        if (cnt_done) state_d = ST_FIRST;
      end
      ST_RECOVER: begin
        if (cnt_done) state_d = ST_FIRST;
      end
      default: begin
        state_d = ST_EVAL;
      end
    endcase
    if (enabled_st && sel_off) state_d = ST_DISABLED;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_EVAL;
      cnt_q <= 32'h0;
      kick_q <= 1'b1;
      fault_n_q <= 1'b1;
      ratio_q <= `SEL_R8;
      cap_pend_q <= 1'b0;
      faults_q <= 32'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= ((state_d != state_q) || restart) ? 32'h0 : cnt_q + 32'h1;
      kick_q <= kick_input;
      fault_n_q <= (state_d != ST_FAULT);
      if (take_ratio) ratio_q <= sel_now;
      if (pend_set) begin
        cap_pend_q <= 1'b1;
      end else if (pend_clr) begin
        cap_pend_q <= 1'b0;
      end
      if (fault_entry) faults_q <= faults_q + 32'h1;
    end
  end

  assign fault_output_n = fault_n_q;

  // ============================================================
  // checks
  // these counters only feed the checks; a few flops buy exact lengths
  logic [31:0] low_run_q;
  logic [31:0] eval_run_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_run_q <= 32'h0;
      eval_run_q <= 32'h0;
    end else begin
      low_run_q <= fault_output_n ? 32'h0 : low_run_q + 32'h1;
      if (state_q == ST_EVAL) eval_run_q <= eval_run_q + 32'h1;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_enter_fault;
    (state_q != ST_FAULT) ##1 (state_q == ST_FAULT);
  endsequence

  sequence s_in_window_kick;
    (state_q == ST_WINDOW) && kick_fall && !sel_off;
  endsequence

  a_eval_period: assert property (
    (state_q == ST_STARTUP) && ($past(state_q) == ST_EVAL) |-> eval_run_q == INIT_CYC)
    else $error("pin evaluation did not last the evaluation time");

  // the classes load on the edge that leaves evaluation, so that cycle is skipped
  a_class_frozen: assert property (
    (state_q != ST_EVAL) && ($past(state_q) != ST_EVAL) |-> $stable(rst_cls) &&
    $stable(wnd_cls))
    else $error("pin class changed after evaluation");

  a_disable_now: assert property (
    enabled_st && sel_off |=> (state_q == ST_DISABLED) && fault_output_n)
    else $error("disable did not act in one cycle");

  a_ratio_held: assert property (
    use_wnd && $changed(sel_now) && !sel_off && (state_d == state_q) |=> $stable(ratio_q))
    else $error("ratio changed without a reset event");

  a_setup_deaf: assert property (
    (state_q == ST_SETUP) && !sel_off && kick_fall |=> state_q inside {ST_SETUP, ST_FIRST})
    else $error("kick acted during the enable settle time");

  a_setup_bound: assert property (
    (state_q == ST_SETUP) |-> cnt_q < SETUP_CYC)
    else $error("enable settle time overran");

  a_cap_recover: assert property (
    (state_q == ST_DISABLED) && cap_pend_q && !sel_off |=> state_q == ST_RECOVER)
    else $error("capacitor delay skipped on re-enable");

  a_recover_high: assert property (
    (state_q == ST_RECOVER) |-> fault_output_n)
    else $error("fault output low during capacitor recovery");

  a_fixed_setup: assert property (
    (state_q == ST_DISABLED) && !cap_pend_q && !sel_off |=> state_q == ST_SETUP)
    else $error("factory delay re-enable skipped settle time");

  a_disabled_high: assert property (
    (state_q == ST_DISABLED) [*2] |-> fault_output_n && (state_d != ST_FAULT))
    else $error("fault output low while disabled");

  a_off_deaf: assert property (
    (state_q == ST_DISABLED) && sel_off && kick_fall |=> state_q == ST_DISABLED)
    else $error("kick acted while disabled");

  a_rise_ignored: assert property (
    (state_q == ST_WINDOW) && !kick_q && kick_input && !cnt_done && !sel_off
    |=> (state_q == ST_WINDOW) && (cnt_q == $past(cnt_q) + 32'h1))
    else $error("rising edge of kick treated as a kick");

  a_level_ignored: assert property (
    use_wnd && (kick_q == kick_input) && !cnt_done && !sel_off |=> state_q == $past(state_q))
    else $error("static kick level treated as a kick");

  a_first_upper: assert property (
    (state_q == ST_FIRST) && kick_fall && !sel_off |=> state_q == ST_WINDOW)
    else $error("first kick was checked against a lower bound");

  a_first_no_lower: assert property (
    (state_q == ST_FIRST) && kick_fall && !sel_off && (cnt_q < wdl_lim) |=> fault_output_n)
    else $error("early first kick raised a fault");

  a_early_fault: assert property (
    s_in_window_kick and (cnt_q < wdl_lim) |=> !fault_output_n)
    else $error("early kick did not raise a fault");

  a_good_kick: assert property (
    s_in_window_kick and (cnt_q >= wdl_lim) |=> fault_output_n && (cnt_q == 32'h0))
    else $error("kick inside the window was not accepted");

  a_late_fault: assert property (
    use_wnd && !kick_fall && cnt_done && !sel_off |=> !fault_output_n)
    else $error("missing kick did not raise a fault");

  a_fault_count: assert property (
    s_enter_fault |-> faults_q == $past(faults_q) + 32'h1)
    else $error("fault entry not counted");

  a_fault_deaf: assert property (
    (state_q == ST_FAULT) && !cnt_done && !sel_off |=> state_q == ST_FAULT)
    else $error("fault left before its delay");

  a_fault_length: assert property (
    $rose(fault_output_n) && (state_q != ST_DISABLED) |-> low_run_q == rst_lim)
    else $error("fault output low for the wrong time");

  a_fault_low: assert property (
    s_enter_fault |-> !fault_output_n)
    else $error("fault state entered with output high");

  a_ratio_lower: assert property (
    (wnd_cls == `CLS_CAP) && (ratio_q == `SEL_R12) |-> wdl_lim == (cap_wdu >> 1))
    else $error("capacitor lower bound off ratio");

  a_delay_pick: assert property (
    (rst_cls == `CLS_PULL) |-> rst_lim == RST_PULL_CYC)
    else $error("pulled-up delay not selected");

  a_startup_high: assert property (
    (state_q == ST_STARTUP) |=> fault_output_n &&
    (state_q inside {ST_STARTUP, ST_DISABLED, ST_SETUP}))
    else $error("fault raised during power-up delay");
endmodule

// ===== sim/kick_host.sv
// ============================================================
// host side: falls the kick line once every gap cycles while go is high
module kick_host (
  input wire logic aclk,
  input wire logic go,
  input wire logic [15:0] gap,
  output logic kick_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q = 16'h0000;
  initial kick_input = 1'b1;
  // a gap below the lower bound is used where a fault is wanted, and while the watchdog is off
  always @(posedge aclk) begin
    if (!go) begin
      cnt_q <= 16'h0000;
      kick_input <= 1'b1;
    end else if (cnt_q + 16'h0001 >= gap) begin
      cnt_q <= 16'h0000;
      kick_input <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      kick_input <= 1'b1;
    end
  end
endmodule

// ===== sim/window_watchdog_timer_bench.sv
module window_watchdog_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import wdt_pkg::*;
  // ============================================================
  // shortened counts so a full run stays small
  localparam int INIT = 20, SETUP = 10, RSTO = 60, RSTP = 30, WDU = 200, WDL = 50;
  logic aclk, aresetn, ratio_select_a, ratio_select_b, kick_input, fault_output_n, go;
  pin_cls_t reset_delay_cfg_pin, window_time_cfg_pin;
  logic [15:0] gap;
  logic [3:0] awaddr, araddr, wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp;
  int fails, check_count, cyc, lows, l0, n;
  window_watchdog_timer #(.INIT_CYC(INIT), .SETUP_CYC(SETUP), .RST_OPEN_CYC(RSTO),
    .RST_PULL_CYC(RSTP), .WDU_OPEN_R8(WDU), .WDU_OPEN_R34(WDU), .WDU_OPEN_R12(WDU),
    .WDU_PULL_R8(WDU), .WDU_PULL_R34(WDU), .WDU_PULL_R12(WDU), .WDL_OPEN_R8(WDL),
    .WDL_OPEN_R34(WDL), .WDL_OPEN_R12(WDL), .WDL_PULL_R8(WDL), .WDL_PULL_R34(WDL),
    .WDL_PULL_R12(WDL)) i_window_watchdog_timer (.aclk, .aresetn, .ratio_select_a,
    .ratio_select_b, .kick_input, .reset_delay_cfg_pin, .window_time_cfg_pin,
    .fault_output_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  kick_host i_kick_host (.aclk, .go, .gap, .kick_input);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= aresetn ? cyc + 1 : 0;
    if (aresetn && fault_output_n !== 1'b1) lows <= lows + 1;
  end
  // ============================================================
  // helpers
  function automatic int rst_len(pin_cls_t c);
    return (c == 2'b01) ? RSTP : RSTO;
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo;
    fails++;
    $display("[ERR] wait expected done seen hang");
    give_verdict;
  endtask
  task automatic cy(int k);
    repeat (k) @(posedge aclk);
  endtask
  // counts negedges where the fault line keeps level v, the first one already seen
  task automatic run(logic v, output int c);
    int i;
    c = 1;
    for (i = 0; i < 5000; i++) begin
      @(negedge aclk);
      if (fault_output_n !== v) break;
      c++;
    end
    if (i == 5000) tmo;
    @(posedge aclk);
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] dt, logic [3:0] s);
    bit da, dw, ha, hw, bv;
    logic [1:0] r;
    int i;
    awaddr <= a; wdata <= dt; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1;
    for (i = 0; i < 50 && !(da && dw); i++) begin
      @(negedge aclk); ha = awready && !da; hw = wready && !dw;
      @(posedge aclk); if (ha) awvalid <= 1'b0; if (hw) wvalid <= 1'b0;
      da |= ha; dw |= hw;
    end
    if (!(da && dw)) tmo;
    bready <= 1'b1;
    for (i = 0; i < 50 && !bv; i++) begin
      @(negedge aclk); bv = bvalid; r = bresp;
      @(posedge aclk);
    end
    bready <= 1'b0;
    if (!bv) tmo;
    chk("bresp", 32'h0, {30'h0, r});
  endtask
  task automatic rd(logic [3:0] a, output logic [31:0] dt);
    bit ha, rv;
    int i;
    logic [1:0] rr;
    araddr <= a; arvalid <= 1'b1;
    for (i = 0; i < 50 && !ha; i++) begin
      @(negedge aclk); ha = arready;
      @(posedge aclk);
    end
    if (!ha) tmo;
    arvalid <= 1'b0; rready <= 1'b1;
    for (i = 0; i < 50 && !rv; i++) begin
      @(negedge aclk); rv = rvalid; dt = rdata; rr = rresp;
      @(posedge aclk);
    end
    rready <= 1'b0;
    if (!rv) tmo;
    chk("rresp", 32'h0, {30'h0, rr});
  endtask
  task automatic st(logic [31:0] m, logic [31:0] e, string nm);
    logic [31:0] v;
    rd(4'h8, v);
    chk(nm, e, v & m);
  endtask
  // ============================================================
  // main sequence
  initial begin
    aresetn = 1'b0; ratio_select_a = 1'b1; ratio_select_b = 1'b0; go = 1'b0; gap = 16'd100;
    reset_delay_cfg_pin = 2'b00; window_time_cfg_pin = 2'b00;
    awaddr = 4'h0; araddr = 4'h0; wstrb = 4'h0; wdata = 32'h0;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    fails = 0; check_count = 0; cyc = 0; lows = 0;
    void'($urandom(32'h7a6012db));
    cy(20);
    aresetn <= 1'b1;
    st(32'h7, 32'h0, "state_eval");
    rd(4'h0, d); chk("cap_rst", 32'h0002ab98, d);
    wr(4'h4, 32'hffffffff, 4'h1);
    rd(4'h4, d); chk("cap_wdu", 32'h000100ff, d);
    while (cyc < INIT + RSTO - 8) cy(1);
    st(32'h7, 32'h1, "state_startup");
    gap <= 16'd20; go <= 1'b1;
    while (cyc < INIT + RSTO + 60) cy(1);
    st(32'hf07, 32'h2, "disabled_cls");
    chk("fault_while_off", 0, lows);
    $display("test power_up done");
    go <= 1'b0; ratio_select_a <= 1'b0;
    cy(1);
    st(32'h7, 32'h3, "state_setup");
    gap <= 16'($urandom_range(WDU - 10, WDL + 10)); go <= 1'b1; l0 = lows;
    cy(800);
    chk("good_kicks", l0, lows);
    st(32'h37, 32'h5, "state_window");
    gap <= 16'd20;
    run(1'b1, n);
    cy(3); ratio_select_a <= 1'b1; cy(1); @(negedge aclk);
    chk("off_releases", 1, fault_output_n);
    cy(1); go <= 1'b0; cy(5); ratio_select_a <= 1'b0;
    cy(1);
    st(32'h7, 32'h3, "reenable_setup");
    $display("test enable_disable done");
    gap <= 16'($urandom_range(WDU - 10, WDL + 10)); go <= 1'b1; cy(300);
    ratio_select_b <= 1'b1; cy(50);
    st(32'h30, 32'h00, "ratio_held");
    gap <= 16'd20;
    run(1'b1, n); go <= 1'b0;
    run(1'b0, n); chk("fault_width", rst_len(2'b00), n);
    run(1'b1, n); chk("first_deadline", 1, n >= WDU - 2 && n <= WDU + 2);
    st(32'h30, 32'h10, "ratio_latched");
    rd(4'hc, d);
    chk("fault_count", 32'h3, d);
    $display("test window_faults done");
    aresetn <= 1'b0; reset_delay_cfg_pin <= 2'b01; cy(20);
    aresetn <= 1'b1;
    while (cyc < INIT + RSTP + 60) cy(1);
    st(32'h307, 32'h104, "pull_class_first");
    gap <= 16'd20; go <= 1'b1;
    run(1'b1, n); run(1'b0, n);
    chk("pull_width", rst_len(2'b01), n);
    $display("test pull_class done");
    give_verdict;
  end
endmodule
